/* rtl/scpc_pkg.sv */
// package: constants and types for the sync clock pin control block
package scpc_pkg;

  // three-level pin encoding as seen by the level sense front end
  typedef enum logic [1:0] {
    SCPC_LVL_LOW   = 2'b00,
    SCPC_LVL_FLOAT = 2'b01,
    SCPC_LVL_HIGH  = 2'b10
  } scpc_level_t;

  // start-up modes chosen by the startup mode pin
  typedef enum logic [1:0] {
    SCPC_MODE_EE_I2C  = 2'b00,
    SCPC_MODE_EE_SPI  = 2'b01,
    SCPC_MODE_ROM_I2C = 2'b10
  } scpc_mode_t;

  // dpll reference choice
  typedef enum logic [1:0] {
    SCPC_REF_PRIMARY   = 2'b00,
    SCPC_REF_AUTO      = 2'b01,
    SCPC_REF_SECONDARY = 2'b10
  } scpc_ref_t;

  // power-on sequencer states
  typedef enum logic [1:0] {
    SCPC_ST_DOWN   = 2'b00,
    SCPC_ST_SAMPLE = 2'b01,
    SCPC_ST_RUN    = 2'b10
  } scpc_state_t;

  localparam int          SCPC_NUM_W          = 40;
  localparam logic [4:0]  SCPC_ADDR_UPPER_RST = 5'h19;
  localparam logic [1:0]  SCPC_ADDR_LSB_ROM   = 2'h0;
  localparam logic [2:0]  SCPC_PAGE_RST       = 3'h0;
  localparam logic [1:0]  SCPC_ADDR_LSB_RST   = 2'h0;
  localparam int          SCPC_ADDR_LSB_POS   = 0;
  localparam int          SCPC_ADDR_UPPER_POS = 2;
  localparam int          SCPC_STEP_SYNC_LAT  = 3;

endpackage

/* rtl/scpc_step_detect.sv */
// module: two-stage synchroniser with rising-edge pulse for a step pin
`timescale 1ns/10ps
module scpc_step_detect (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic pin_in,
  output logic      rise_pulse
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // meta_q feeds sync_q only
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= sync_q;
    end
  end

  // one pulse per rising edge, whatever the high time
  assign rise_pulse = sync_q & ~prev_q;

endmodule

/* rtl/scpc_top.sv */
// module: pin-level control of a network clock synchroniser
`timescale 1ns/10ps
//
// Behaviour
// - sample startup mode pin at power-on reset
// - eeprom i2c: address lsbs from select pin
// - step-up pulse adds step to numerator
// - step-down pulse subtracts step from numerator
// - reference pin picks dpll input when hardware-controlled
// - reference pin ignored for auto or software
// - status outputs programmable, open-drain or push-pull
// - rom mode: page pins sampled at reset
// - rom mode: page bit2 becomes step-up after reset
// - rom mode: status b becomes step-down after reset
// - rom i2c mode forces address lsbs zero
// - spi mode: select pin chip select, step-up data out
module scpc_top #(
  parameter int NUM_W = scpc_pkg::SCPC_NUM_W
) (
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  input  wire logic                  pdn_n,
  input  wire logic [1:0]            startup_mode_pin,
  input  wire logic [1:0]            addr_select_pin,
  input  wire logic                  page_bit0_pin,
  input  wire logic                  page_bit1_pin,
  input  wire logic                  page_bit2_pin,
  input  wire logic [1:0]            ref_choice_pin,
  input  wire logic                  status_b_in,
  input  wire logic                  dco_mode_en,
  input  wire logic                  pin_ctrl_en,
  input  wire logic                  manual_sel_en,
  input  wire logic                  hw_ref_ctrl_en,
  input  wire logic [1:0]            sw_ref_sel,
  input  wire logic [NUM_W-1:0]      freq_step_amount,
  input  wire logic [NUM_W-1:0]      num_init,
  input  wire logic [4:0]            addr_upper,
  input  wire logic                  status_a_func,
  input  wire logic                  status_b_func,
  input  wire logic                  status_a_od,
  input  wire logic                  status_b_od,
  input  wire logic                  spi_sdo_data,
  input  wire logic                  spi_sdo_en,
  output logic [NUM_W-1:0]           dco_num_q,
  output scpc_pkg::scpc_mode_t       mode_q,
  output logic [2:0]                 rom_page_q,
  output logic [6:0]                 target_address_field_q,
  output scpc_pkg::scpc_ref_t        ref_sel_q,
  output logic                       spi_cs_n_q,
  output logic                       page_bit2_out_q,
  output logic                       page_bit2_oe_q,
  output logic                       status_out_a_q,
  output logic                       status_out_a_oe_q,
  output logic                       status_out_b_q,
  output logic                       status_out_b_oe_q,
  output logic                       running_q
);

  // ******************************
  // pin synchronisers
  // ******************************
  logic [10:0] pin_meta_q;
  logic [10:0] pin_sync_q;
  logic [10:0] pin_raw;

  assign pin_raw = {pdn_n, startup_mode_pin, addr_select_pin, page_bit0_pin, page_bit1_pin,
                    ref_choice_pin, 2'b00};

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  logic       pdn_s;
  logic [1:0] mode_s;
  logic [1:0] addr_s;
  logic [1:0] ref_s;
  logic       pg0_s;
  logic       pg1_s;

  assign pdn_s  = pin_sync_q[10];
  assign mode_s = pin_sync_q[9:8];
  assign addr_s = pin_sync_q[7:6];
  assign pg0_s  = pin_sync_q[5];
  assign pg1_s  = pin_sync_q[4];
  assign ref_s  = pin_sync_q[3:2];

  // page bit2 is also the step-up pin, status b the step-down pin
  logic pg2_meta_q;
  logic pg2_s_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pg2_meta_q <= 1'b0;
      pg2_s_q    <= 1'b0;
    end else begin
      pg2_meta_q <= page_bit2_pin;
      pg2_s_q    <= pg2_meta_q;
    end
  end

  // ******************************
  // power-on sequencer
  // ******************************
  scpc_pkg::scpc_state_t st_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= scpc_pkg::SCPC_ST_DOWN;
    end else begin
      case (st_q)
        scpc_pkg::SCPC_ST_DOWN: begin
          if (pdn_s) begin
            st_q <= scpc_pkg::SCPC_ST_SAMPLE;
          end
        end
        scpc_pkg::SCPC_ST_SAMPLE: begin
          st_q <= scpc_pkg::SCPC_ST_RUN;
        end
        scpc_pkg::SCPC_ST_RUN: begin
          if (!pdn_s) begin
            st_q <= scpc_pkg::SCPC_ST_DOWN;
          end
        end
        default: begin
          st_q <= scpc_pkg::SCPC_ST_DOWN;
        end
      endcase
    end
  end

  logic sample_now;
  assign sample_now = (st_q == scpc_pkg::SCPC_ST_SAMPLE);

  function automatic scpc_pkg::scpc_mode_t lvl_to_mode(input logic [1:0] lvl);
    case (lvl)
      scpc_pkg::SCPC_LVL_LOW:   lvl_to_mode = scpc_pkg::SCPC_MODE_EE_I2C;
      scpc_pkg::SCPC_LVL_FLOAT: lvl_to_mode = scpc_pkg::SCPC_MODE_EE_SPI;
      default:                  lvl_to_mode = scpc_pkg::SCPC_MODE_ROM_I2C;
    endcase
  endfunction

  // ******************************
  // start-up straps
  // ******************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_q                 <= scpc_pkg::SCPC_MODE_EE_I2C;
      rom_page_q             <= scpc_pkg::SCPC_PAGE_RST;
      target_address_field_q <= {scpc_pkg::SCPC_ADDR_UPPER_RST, scpc_pkg::SCPC_ADDR_LSB_RST};
    end else if (sample_now) begin
      mode_q <= lvl_to_mode(mode_s);
      if (lvl_to_mode(mode_s) == scpc_pkg::SCPC_MODE_ROM_I2C) begin
        rom_page_q             <= {pg2_s_q, pg1_s, pg0_s};
        target_address_field_q <= {addr_upper, scpc_pkg::SCPC_ADDR_LSB_ROM};
      end else begin
        // float code 01 and high code 10 map straight onto the lsbs
        target_address_field_q <= {addr_upper, addr_s};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      running_q <= 1'b0;
    end else begin
      running_q <= (st_q == scpc_pkg::SCPC_ST_RUN);
    end
  end

  // ******************************
  // dco numerator stepping
  // ******************************
  logic up_pulse;
  logic dn_pulse;
  logic in_run;
  logic step_ok;

  assign in_run = (st_q == scpc_pkg::SCPC_ST_RUN);

  scpc_step_detect u_up (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .pin_in     (page_bit2_pin),
    .rise_pulse (up_pulse)
  );

  // status b reads back as input only while its driver is off
  scpc_step_detect u_dn (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .pin_in     (status_b_in),
    .rise_pulse (dn_pulse)
  );

  // spi mode owns page bit2 as data out, so stepping is off there
  assign step_ok = in_run && dco_mode_en && pin_ctrl_en &&
                   (mode_q != scpc_pkg::SCPC_MODE_EE_SPI);

  always_ff @(posedge sys_clk) begin
    if (srst || !in_run) begin
      dco_num_q <= num_init;
    end else if (step_ok && up_pulse && !dn_pulse) begin
      dco_num_q <= dco_num_q + freq_step_amount;
    end else if (step_ok && dn_pulse && !up_pulse) begin
      dco_num_q <= dco_num_q - freq_step_amount;
    end
  end

  // ******************************
  // reference selection
  // ******************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ref_sel_q <= scpc_pkg::SCPC_REF_PRIMARY;
    end else if (manual_sel_en && hw_ref_ctrl_en) begin
      case (ref_s)
        scpc_pkg::SCPC_LVL_LOW:   ref_sel_q <= scpc_pkg::SCPC_REF_PRIMARY;
        scpc_pkg::SCPC_LVL_FLOAT: ref_sel_q <= scpc_pkg::SCPC_REF_AUTO;
        default:                  ref_sel_q <= scpc_pkg::SCPC_REF_SECONDARY;
      endcase
    end else if (!manual_sel_en) begin
      ref_sel_q <= scpc_pkg::SCPC_REF_AUTO;
    end else begin
      ref_sel_q <= scpc_pkg::scpc_ref_t'(sw_ref_sel);
    end
  end

  // ******************************
  // pin reassignment and status drivers
  // ******************************
  logic spi_mode;
  assign spi_mode = in_run && (mode_q == scpc_pkg::SCPC_MODE_EE_SPI);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      spi_cs_n_q      <= 1'b1;
      page_bit2_out_q <= 1'b0;
      page_bit2_oe_q  <= 1'b0;
    end else begin
      spi_cs_n_q      <= spi_mode ? addr_s[0] : 1'b1;
      page_bit2_out_q <= spi_mode & spi_sdo_data;
      page_bit2_oe_q  <= spi_mode & spi_sdo_en;
    end
  end

  // status pins stay undriven until running so straps can be sensed
  always_ff @(posedge sys_clk) begin
    if (srst || !in_run) begin
      status_out_a_q    <= 1'b0;
      status_out_a_oe_q <= 1'b0;
      status_out_b_q    <= 1'b0;
      status_out_b_oe_q <= 1'b0;
    end else begin
      status_out_a_q    <= status_a_func;
      status_out_a_oe_q <= status_a_od ? ~status_a_func : 1'b1;
      // status b turns into the step-down input when dco mode and pin control are both on
      status_out_b_q    <= status_b_func;
      status_out_b_oe_q <= (dco_mode_en && pin_ctrl_en) ? 1'b0 :
                           (status_b_od ? ~status_b_func : 1'b1);
    end
  end

endmodule

/* sim/scpc_checker.sv */
// checker: port-level assertions for the sync clock pin control block
`timescale 1ns/10ps
module scpc_checker #(
  parameter int NUM_W = 40
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic page_bit2_pin,
  input wire logic status_b_in,
  input wire logic dco_mode_en,
  input wire logic pin_ctrl_en,
  input wire logic manual_sel_en,
  input wire logic hw_ref_ctrl_en,
  input wire logic [1:0] ref_choice_pin,
  input wire logic [1:0] addr_select_pin,
  input wire logic [1:0] startup_mode_pin,
  input wire logic status_a_func,
  input wire logic status_a_od,
  input wire logic [NUM_W-1:0] freq_step_amount,
  input wire logic [NUM_W-1:0] dco_num_q,
  input wire scpc_pkg::scpc_mode_t mode_q,
  input wire logic [6:0] target_address_field_q,
  input wire scpc_pkg::scpc_ref_t ref_sel_q,
  input wire logic status_out_a_oe_q,
  input wire logic status_out_b_oe_q,
  input wire logic running_q
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic ok;
  // steps only count while running, enabled and not in spi mode
  assign ok = running_q && dco_mode_en && pin_ctrl_en && mode_q != scpc_pkg::SCPC_MODE_EE_SPI;
  AST_STEP_UP: assert property ($rose(page_bit2_pin) && ok && !status_b_in |->
    ##[2:4] dco_num_q == NUM_W'($past(dco_num_q) + freq_step_amount)) else $error("no step up");
  AST_STEP_DOWN: assert property ($rose(status_b_in) && ok && !page_bit2_pin |->
    ##[2:4] dco_num_q == NUM_W'($past(dco_num_q) - freq_step_amount)) else $error("no step down");
  AST_STEP_GATED: assert property ((running_q && !(dco_mode_en && pin_ctrl_en))[*5] |->
    $stable(dco_num_q)) else $error("step while disabled");
  AST_ONE_PER_EDGE: assert property (running_q && $changed(dco_num_q) |=>
    $stable(dco_num_q)) else $error("two steps in a row");
  AST_STRAP: assert property ($rose(running_q) |-> mode_q == scpc_pkg::scpc_mode_t'(startup_mode_pin)
    && (mode_q != scpc_pkg::SCPC_MODE_EE_I2C || target_address_field_q[1:0] == addr_select_pin))
    else $error("strap not captured");
  AST_REF_PIN: assert property ((running_q && manual_sel_en && hw_ref_ctrl_en &&
    $stable(ref_choice_pin))[*4] |-> ref_sel_q == scpc_pkg::scpc_ref_t'(ref_choice_pin))
    else $error("reference pin not followed");
  AST_STATUS_DRIVE: assert property ((running_q && $stable({status_a_od, status_a_func}))[*3]
    |-> status_out_a_oe_q == !(status_a_od && status_a_func)) else $error("status driver type");
  AST_STATUS_QUIET: assert property ((!running_q)[*2] |->
    !status_out_a_oe_q && !status_out_b_oe_q) else $error("status driven at start-up");
  cover property ($rose(running_q) && mode_q == scpc_pkg::SCPC_MODE_ROM_I2C);
  cover property ($rose(page_bit2_pin) && ok);
  cover property ($rose(status_b_in) && ok);
endmodule
bind scpc_top scpc_checker #(.NUM_W(NUM_W)) scpc_checker_i (.*);

/* sim/scpc_host_model.sv */
// host model: pulses the step pins, leaves status b released at power-on
`timescale 1ns/10ps
module scpc_host_model (
  input  wire logic sys_clk,
  input  wire logic status_out_b_q,
  input  wire logic status_out_b_oe_q,
  output logic      page_bit2_pin,
  output logic      status_b_in
);
  logic drv_b = 1'b0;
  logic dn_q  = 1'b0;
  logic flt_q = 1'b0;
  // a released line has no level: toggle so a stale value is never trusted
  always @(posedge sys_clk) flt_q <= ~flt_q;
  assign status_b_in = status_out_b_oe_q ? status_out_b_q : (drv_b ? dn_q : flt_q);
  initial page_bit2_pin = 1'b0;
  task automatic pulse(input logic up, input int hi);
    @(posedge sys_clk);
    #1;
    if (up) page_bit2_pin = 1'b1; else dn_q = 1'b1;
    repeat (hi) @(posedge sys_clk);
    #1;
    page_bit2_pin = 1'b0;
    dn_q = 1'b0;
  endtask
endmodule

/* sim/test_scpc_top.sv */
// testbench: straps, step pins, reference choice and status drivers
`timescale 1ns/10ps
module test_scpc_top;
  localparam int NUM_W = 40;
  logic sys_clk, srst, pdn_n, page_bit0_pin, page_bit1_pin, page_bit2_pin, status_b_in;
  logic [1:0] startup_mode_pin, addr_select_pin, ref_choice_pin, sw_ref_sel;
  logic dco_mode_en, pin_ctrl_en, manual_sel_en, hw_ref_ctrl_en, spi_sdo_data, spi_sdo_en;
  logic status_a_func, status_b_func, status_a_od, status_b_od, spi_cs_n_q, running_q;
  logic [NUM_W-1:0] freq_step_amount, num_init, dco_num_q;
  logic [4:0] addr_upper;
  logic [2:0] rom_page_q;
  logic [6:0] target_address_field_q;
  scpc_pkg::scpc_mode_t mode_q;
  scpc_pkg::scpc_ref_t ref_sel_q;
  logic page_bit2_out_q, page_bit2_oe_q, status_out_a_q, status_out_a_oe_q;
  logic status_out_b_q, status_out_b_oe_q;
  int n_errors, comparisons;
  scpc_top #(.NUM_W(NUM_W)) scpc_top_i (.*);
  scpc_host_model scpc_host_model_i (.sys_clk(sys_clk), .status_out_b_q(status_out_b_q),
    .status_out_b_oe_q(status_out_b_oe_q), .page_bit2_pin(page_bit2_pin),
    .status_b_in(status_b_in));
  // ****************************************
  // tasks
  // ****************************************
  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic boot(input logic [1:0] mode, input logic [1:0] adr, input logic [2:0] pg);
    int i;
    srst = 1'b1;
    pdn_n = 1'b0;
    scpc_host_model_i.drv_b = 1'b0;
    startup_mode_pin = mode;
    addr_select_pin = adr;
    {scpc_host_model_i.page_bit2_pin, page_bit1_pin, page_bit0_pin} = pg;
    tick(20);
    srst = 1'b0;
    pdn_n = 1'b1;
    for (i = 0; i < 50 && running_q !== 1'b1; i++) begin
      chk(status_out_b_oe_q, 0);
      tick();
    end
    if (running_q !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t start-up timed out", $time);
      report_and_stop();
    end
    scpc_host_model_i.page_bit2_pin = 1'b0;
    scpc_host_model_i.drv_b = 1'b1;
    // flush edges of the released status b line out of the synchroniser before stepping
    tick(4);
  endtask
  task automatic step(input logic up, input logic [NUM_W-1:0] exp);
    scpc_host_model_i.pulse(up, 4);
    tick(6);
    chk(dco_num_q, exp);
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    n_errors = 0;
    comparisons = 0;
    {dco_mode_en, pin_ctrl_en, manual_sel_en, hw_ref_ctrl_en} = 4'h0;
    {status_a_func, status_b_func, status_a_od, status_b_od, spi_sdo_data, spi_sdo_en} = 6'h0;
    {ref_choice_pin, sw_ref_sel, addr_upper} = {2'h0, 2'h2, 5'h19};
    {freq_step_amount, num_init} = {40'h0000001234, 40'h8000000000};
    boot(2'h0, 2'h1, 3'h0);
    chk({mode_q, target_address_field_q}, {scpc_pkg::SCPC_MODE_EE_I2C, 5'h19, 2'h1});
    {dco_mode_en, pin_ctrl_en} = 2'h3;
    step(1'b1, num_init + freq_step_amount);
    step(1'b0, num_init);
    scpc_host_model_i.pulse(1'b1, 3);
    scpc_host_model_i.pulse(1'b1, 3);
    tick(6);
    chk(dco_num_q, num_init + 2 * freq_step_amount);
    pin_ctrl_en = 1'b0;
    step(1'b1, num_init + 2 * freq_step_amount);
    {manual_sel_en, hw_ref_ctrl_en} = 2'h3;
    for (int k = 0; k < 3; k++) begin
      ref_choice_pin = 2'(k);
      tick(5);
      chk(ref_sel_q, k);
    end
    hw_ref_ctrl_en = 1'b0;
    tick(5);
    chk(ref_sel_q, scpc_pkg::SCPC_REF_SECONDARY);
    manual_sel_en = 1'b0;
    tick(5);
    chk(ref_sel_q, scpc_pkg::SCPC_REF_AUTO);
    {status_a_od, status_a_func} = 2'h3;
    tick(4);
    chk(status_out_a_oe_q, 0);
    status_a_od = 1'b0;
    tick(4);
    chk({status_out_a_oe_q, status_out_a_q}, 2'h3);
    {dco_mode_en, pin_ctrl_en} = 2'h0;
    boot(2'h2, 2'h2, 3'h5);
    chk({mode_q, rom_page_q, target_address_field_q}, {scpc_pkg::SCPC_MODE_ROM_I2C, 3'h5, 7'h64});
    {dco_mode_en, pin_ctrl_en} = 2'h3;
    step(1'b1, num_init + freq_step_amount);
    step(1'b0, num_init);
    {dco_mode_en, pin_ctrl_en} = 2'h0;
    boot(2'h1, 2'h0, 3'h0);
    {dco_mode_en, pin_ctrl_en, spi_sdo_en, spi_sdo_data} = 4'hf;
    tick(4);
    chk({mode_q, spi_cs_n_q, page_bit2_oe_q, page_bit2_out_q}, {scpc_pkg::SCPC_MODE_EE_SPI, 3'h3});
    spi_sdo_en = 1'b0;
    step(1'b1, num_init);
    report_and_stop();
  end
endmodule
